// ### ufs_cfg.svh
/*
  constants of the port fault supervisor: register offsets, field
  positions, reset values, event indices and timing counts.
  assumes a 20 MHz core clock and a word-aligned 32-bit register bus.
*/
`ifndef UFS_CFG_SVH
`define UFS_CFG_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define UFS_CLK_KHZ        20000
`define UFS_OVERTEMP_WARNING_FLAG_MS    20
`define UFS_OC_MS          16
`define UFS_VCONN_MS       1
`define UFS_RETRY_MS       64
`define UFS_MS_TO_CYC(ms)  ((ms) * `UFS_CLK_KHZ)
`define UFS_LX_RUN         3'h4

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define UFS_FLAGS_OFS      8'h00
`define UFS_MASK_OFS       8'h04
`define UFS_CTRL_OFS       8'h08
`define UFS_STATE_OFS      8'h0c

// ****************************************************************
// control fields and reset values
// ****************************************************************
`define UFS_CTRL_TRIP_SEL  0
`define UFS_CTRL_FOLDBACK  1
`define UFS_CTRL_CUR_LO    2
`define UFS_CTRL_CUR_HI    3
`define UFS_CTRL_VCONN     4
`define UFS_CTRL_RST       5'h1e
`define UFS_MASK_RST       11'h000

// ****************************************************************
// event indices and action masks
// ****************************************************************
`define UFS_NUM_EV         11
`define UFS_EV_OVERTEMP_SHUTDOWN_FLAG     0
`define UFS_EV_OVERTEMP_WARNING_FLAG    1
`define UFS_EV_INPUT_OVERVOLTAGE_FLAG       2
`define UFS_EV_DATALINE_OVERVOLTAGE_FLAG     3
`define UFS_EV_BUS_ILIM    4
`define UFS_EV_ILIM_UV     5
`define UFS_EV_BUS_UV      6
`define UFS_EV_SHT_GND     7
`define UFS_EV_SENSE_OV    8
`define UFS_EV_VCONN_OC    9
`define UFS_EV_PREON_OV    10
`define UFS_SHUT_MASK      11'h18d
`define UFS_BC_MASK        11'h00c
`define UFS_PIN_MASK       11'h7fd

`endif

// ### ufs_pkg.sv
/*
  types shared by the port fault supervisor and its event tracker.
  assumes ufs_cfg.svh for all numeric constants.
*/
package ufs_pkg;
  typedef logic [10:0] ufs_ev_vec_t;
  typedef logic [23:0] ufs_cnt_t;
  typedef enum logic {UFS_EV_IDLE, UFS_EV_ACTIVE} ufs_ev_state_t;
endpackage

// ### ufs_event.sv
/*
  one fault event: debounce of a synchronised condition, then a held
  fault with its own recovery wait timer.
  assumes cond is already synchronous to core_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module ufs_event
#(
  parameter int unsigned DEB_CYCLES = 0
)
(
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst,
  // condition and recovery setup
  input  wire logic            cond,
  input  wire logic            from_trip,
  input  wire ufs_pkg::ufs_cnt_t retry_cycles,
  // result
  output logic                 active,
  output logic                 trip
);
  import ufs_pkg::*;

  localparam ufs_cnt_t DEB_LAST = (DEB_CYCLES == 0) ? '0 : ufs_cnt_t'(DEB_CYCLES - 1);

  ufs_ev_state_t state_q;
  ufs_cnt_t      deb_q;
  ufs_cnt_t      retry_q;
  logic          trip_q;
  logic          deb_done;
  logic          expired;

  assign deb_done = cond && ((DEB_CYCLES == 0) || (deb_q == DEB_LAST));
  assign expired  = (retry_q >= retry_cycles);
  assign active   = (state_q == UFS_EV_ACTIVE);
  assign trip     = trip_q;

  // ****************************************************************
  // debounce
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst || state_q != UFS_EV_IDLE || !cond)
      deb_q <= '0;
    else if (!deb_done)
      deb_q <= deb_q + 24'h000001;
  end

  // ****************************************************************
  // recovery wait timer
  // ****************************************************************
  // counts from the trip or from the clear; a returning condition
  // restarts the clear-started kind
  always_ff @(posedge core_clk)
  begin
    if (rst || state_q == UFS_EV_IDLE)
      retry_q <= '0;
    else if ((from_trip || !cond) && !expired)
      retry_q <= retry_q + 24'h000001;
    else if (!from_trip && cond)
      retry_q <= '0;
  end

  // ****************************************************************
  // event state
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q <= UFS_EV_IDLE;
      trip_q  <= 1'b0;
    end
    else
    begin
      trip_q <= 1'b0;
      unique case (state_q)
        UFS_EV_IDLE:
          if (deb_done)
          begin
            state_q <= UFS_EV_ACTIVE;
            trip_q  <= 1'b1;
          end
        UFS_EV_ACTIVE:
          if (expired && !cond)
            state_q <= UFS_EV_IDLE;
      endcase
    end
  end
endmodule

`default_nettype wire

// ### ufs_supervisor.sv
/*
  fault supervisor of a usb type-c host port power stage: debounces
  fault conditions, raises flags and the open-drain fault output, and
  steers converter, data switches, pull-up, bc1.2 reset, cable power
  and advertised current. wishbone classic slave for software.
  assumes comparator inputs are asynchronous levels and that the fault
  pin is pulled up externally.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ufs_cfg.svh"

module ufs_supervisor
#(
  parameter int unsigned OVERTEMP_WARNING_FLAG_CYC = `UFS_MS_TO_CYC(`UFS_OVERTEMP_WARNING_FLAG_MS),
  parameter int unsigned OC_CYC       = `UFS_MS_TO_CYC(`UFS_OC_MS),
  parameter int unsigned VCONN_CYC    = `UFS_MS_TO_CYC(`UFS_VCONN_MS),
  parameter int unsigned RETRY_CYC    = `UFS_MS_TO_CYC(`UFS_RETRY_MS)
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // wishbone classic slave
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_wdat,
  output logic [31:0]      wb_rdat,
  output logic             wb_ack,
  // fault conditions from comparators
  input  wire logic        overtemp_shutdown,
  input  wire logic        overtemp_warning,
  input  wire logic        input_overvoltage,
  input  wire logic        dataline_overvoltage,
  input  wire logic        bus_overcurrent,
  input  wire logic        sense_below_uv,
  input  wire logic        sense_below_short,
  input  wire logic        sense_overvoltage,
  input  wire logic        cable_power_overcurrent,
  input  wire logic        preon_overvoltage,
  input  wire logic        switch_node_overcurrent,
  input  wire logic        switch_node_cycle,
  input  wire logic        cable_unattached,
  // open-drain fault pin
  input  wire logic        fault_n_in,
  output logic             fault_n_out,
  output logic             fault_n_oe,
  // interrupt and power stage controls
  output logic             irq,
  output logic             converter_enable,
  output logic             data_switch_close,
  output logic             rp_enable,
  output logic             bc12_reset,
  output logic             vconn_enable,
  output logic [1:0]       advertised_current
);
  import ufs_pkg::*;

  localparam int unsigned DEB_TAB [0:10] = '{
    0, OVERTEMP_WARNING_FLAG_CYC, 0, 0, OC_CYC, OC_CYC, OC_CYC, 0, 0, VCONN_CYC, OC_CYC
  };

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [13:0] raw;
  logic [13:0] sync1_q;
  logic [13:0] sync2_q;

  assign raw = {fault_n_in, cable_unattached, switch_node_cycle,
                switch_node_overcurrent, preon_overvoltage,
                cable_power_overcurrent, sense_overvoltage,
                sense_below_short, sense_below_uv, bus_overcurrent,
                dataline_overvoltage, input_overvoltage,
                overtemp_warning, overtemp_shutdown};

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sync1_q <= 14'h0000;
      sync2_q <= 14'h0000;
    end
    else
    begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
    end
  end

  logic bus_oc_s;
  logic below_uv_s;
  logic below_short_s;
  logic sw_oc_s;
  logic sw_cycle_s;
  logic unattached_s;
  logic pin_level_s;

  assign bus_oc_s      = sync2_q[4];
  assign below_uv_s    = sync2_q[5];
  assign below_short_s = sync2_q[6];
  assign sw_oc_s       = sync2_q[10];
  assign sw_cycle_s    = sync2_q[11];
  assign unattached_s  = sync2_q[12];
  assign pin_level_s   = sync2_q[13];

  // ****************************************************************
  // switch node overcurrent run
  // ****************************************************************
  logic       sw_cycle_prev_q;
  logic [2:0] lx_run_q;
  logic       lx_short;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      sw_cycle_prev_q <= 1'b0;
    else
      sw_cycle_prev_q <= sw_cycle_s;
  end

  // overcurrent cycles in a row; cleared while the converter is off, so no stale run trips later
  always_ff @(posedge core_clk)
  begin
    if (rst || !converter_enable)
      lx_run_q <= 3'h0;
    else if (sw_cycle_s && !sw_cycle_prev_q)
    begin
      if (!sw_oc_s)
        lx_run_q <= 3'h0;
      else if (lx_run_q != `UFS_LX_RUN)
        lx_run_q <= lx_run_q + 3'h1;
    end
  end

  assign lx_short = (lx_run_q == `UFS_LX_RUN);

  // ****************************************************************
  // control register fields
  // ****************************************************************
  logic [4:0]  ctrl_q;
  ufs_ev_vec_t mask_q;
  ufs_ev_vec_t flags_q;
  logic        trip_sel;

  assign trip_sel = ctrl_q[`UFS_CTRL_TRIP_SEL];

  // ****************************************************************
  // fault events
  // ****************************************************************
  ufs_ev_vec_t cond;
  ufs_ev_vec_t from_trip;
  ufs_ev_vec_t active;
  ufs_ev_vec_t trip;

  always_comb
  begin
    cond                       = sync2_q[10:0];
    cond[`UFS_EV_ILIM_UV]      = bus_oc_s && below_uv_s;
    cond[`UFS_EV_BUS_UV]       = below_uv_s;
    cond[`UFS_EV_SHT_GND]      = (bus_oc_s || lx_short) && below_short_s;
    cond[`UFS_EV_SENSE_OV]     = sync2_q[7];
    cond[`UFS_EV_VCONN_OC]     = sync2_q[8];
    cond[`UFS_EV_PREON_OV]     = sync2_q[9];
    from_trip                  = '0;
    from_trip[`UFS_EV_SHT_GND] = 1'b1;
    from_trip[`UFS_EV_ILIM_UV] = !trip_sel;
  end

  for (genvar i = 0; i < `UFS_NUM_EV; i++)
  begin : g_ev
    ufs_event
    #(
      .DEB_CYCLES (DEB_TAB[i])
    )
    u_event
    (
      .core_clk     (core_clk),
      .rst          (rst),
      .cond         (cond[i]),
      .from_trip    (from_trip[i]),
      .retry_cycles (ufs_cnt_t'(RETRY_CYC)),
      .active       (active[i]),
      .trip         (trip[i])
    );
  end

  // ****************************************************************
  // power stage actions
  // ****************************************************************
  ufs_ev_vec_t shut_mask;
  logic        shut;
  logic        sw_open;
  logic        reporting;
  logic        foldback;
  logic [1:0]  cfg_cur;
  logic        vconn_lock_q;

  // the combined trip only shuts down in the hard trip mode
  always_comb
  begin
    shut_mask                  = `UFS_SHUT_MASK;
    shut_mask[`UFS_EV_ILIM_UV] = !trip_sel;
  end

  assign shut      = |(active & shut_mask);
  assign sw_open   = |(active & `UFS_SHUT_MASK);
  assign reporting = |(active & `UFS_PIN_MASK);
  assign cfg_cur   = ctrl_q[`UFS_CTRL_CUR_HI:`UFS_CTRL_CUR_LO];
  assign foldback  = active[`UFS_EV_OVERTEMP_WARNING_FLAG] && ctrl_q[`UFS_CTRL_FOLDBACK];

  // cable power stays off after its overcurrent until a detach is seen
  always_ff @(posedge core_clk)
  begin
    if (rst)
      vconn_lock_q <= 1'b0;
    else if (trip[`UFS_EV_VCONN_OC])
      vconn_lock_q <= 1'b1;
    else if (unattached_s && !active[`UFS_EV_VCONN_OC])
      vconn_lock_q <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      fault_n_out        <= 1'b0;
      fault_n_oe         <= 1'b0;
      converter_enable   <= 1'b0;
      data_switch_close  <= 1'b0;
      rp_enable          <= 1'b0;
      bc12_reset         <= 1'b0;
      vconn_enable       <= 1'b0;
      advertised_current <= 2'h0;
    end
    else
    begin
      fault_n_out        <= 1'b0;
      fault_n_oe         <= reporting;
      converter_enable   <= !shut;
      data_switch_close  <= !sw_open;
      rp_enable          <= !shut;
      bc12_reset         <= |(active & `UFS_BC_MASK);
      vconn_enable       <= ctrl_q[`UFS_CTRL_VCONN] && !vconn_lock_q &&
                            !active[`UFS_EV_VCONN_OC];
      advertised_current <= (foldback && cfg_cur != 2'h0) ? cfg_cur - 2'h1 : cfg_cur;
    end
  end

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  logic        req;
  logic        rd_req;
  logic        wr_req;
  logic [7:0]  adr;
  logic [31:0] rd_d;
  ufs_ev_vec_t clr;
  ufs_ev_vec_t flags_d;

  // one wait state: ack rises the edge after the request is seen
  assign req    = wb_cyc && wb_stb && !wb_ack;
  assign rd_req = req && !wb_we;
  assign wr_req = req && wb_we;
  assign adr    = {wb_adr[7:2], 2'b00};

  always_comb
  begin
    unique case (adr)
      `UFS_FLAGS_OFS: rd_d = {21'h000000, flags_q};
      `UFS_MASK_OFS:  rd_d = {21'h000000, mask_q};
      `UFS_CTRL_OFS:  rd_d = {27'h0000000, ctrl_q};
      `UFS_STATE_OFS: rd_d = {7'h00, pin_level_s, 2'h0, advertised_current,
                              vconn_enable, rp_enable, data_switch_close,
                              converter_enable, 5'h00, active};
      default:        rd_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wb_ack  <= 1'b0;
      wb_rdat <= 32'h00000000;
    end
    else
    begin
      wb_ack <= req;
      if (rd_req)
        wb_rdat <= rd_d;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      mask_q <= `UFS_MASK_RST;
      ctrl_q <= `UFS_CTRL_RST;
    end
    else if (wr_req)
    begin
      if (adr == `UFS_MASK_OFS && wb_sel[0])
        mask_q[7:0] <= wb_wdat[7:0];
      if (adr == `UFS_MASK_OFS && wb_sel[1])
        mask_q[10:8] <= wb_wdat[10:8];
      if (adr == `UFS_CTRL_OFS && wb_sel[0])
        ctrl_q <= wb_wdat[4:0];
    end
  end

  // ****************************************************************
  // flags and interrupt
  // ****************************************************************
  // a read clears all flags, a write of ones clears those bits; a new
  // trip in the same cycle wins, a still-active event sets again next
  always_comb
  begin
    clr = '0;
    if (rd_req && adr == `UFS_FLAGS_OFS)
      clr = '1;
    else if (wr_req && adr == `UFS_FLAGS_OFS)
      clr = wb_wdat[10:0] & {{3{wb_sel[1]}}, {8{wb_sel[0]}}};
    flags_d = (flags_q & ~clr) | trip | (active & ~clr);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      flags_q <= '0;
      irq     <= 1'b0;
    end
    else
    begin
      flags_q <= flags_d;
      irq     <= |(flags_d & mask_q);
    end
  end
endmodule

`default_nettype wire

// ### ufs_supervisor_asserts.sv
/*
  checker for the port fault supervisor: fault pin, bus answer,
  shutdown timing and recovery wait.
  assumes bench stimulus changes just after the core clock edge.
*/
`timescale 1ns/100ps
`default_nettype none

module ufs_supervisor_asserts
#(
  parameter int unsigned OVERTEMP_WARNING_FLAG_CYC = 20,
  parameter int unsigned OC_CYC       = 16,
  parameter int unsigned VCONN_CYC    = 5,
  parameter int unsigned RETRY_CYC    = 10
)
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // bus and conditions
  input  wire logic wb_ack,
  input  wire logic overtemp_shutdown,
  input  wire logic input_overvoltage,
  input  wire logic bus_overcurrent,
  input  wire logic sense_below_short,
  input  wire logic sense_overvoltage,
  input  wire logic cable_power_overcurrent,
  // pin and power stage
  input  wire logic fault_n_out,
  input  wire logic fault_n_oe,
  input  wire logic converter_enable,
  input  wire logic data_switch_close,
  input  wire logic rp_enable,
  input  wire logic bc12_reset,
  input  wire logic vconn_enable
);
  int unsigned quiet_q;
  int unsigned cable_run_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // ****************
  // helper logic
  // ****************
  // cycles since overtemp was last seen, saturating
  always_ff @(posedge core_clk)
  begin
    if (rst || overtemp_shutdown)
      quiet_q <= 32'h0;
    else if (quiet_q < RETRY_CYC)
      quiet_q <= quiet_q + 32'h1;
  end

  // consecutive cycles of cable power overcurrent at the pin, saturating;
  // a counter instead of a repetition so real debounce lengths still work
  always_ff @(posedge core_clk)
  begin
    if (rst || !cable_power_overcurrent)
      cable_run_q <= 32'h0;
    else if (cable_run_q < VCONN_CYC + 32'h8)
      cable_run_q <= cable_run_q + 32'h1;
  end

  // ****************
  // properties
  // ****************
  a_pin_sinks_low: assert property (fault_n_oe |-> !fault_n_out)
    else $error("fault pin enabled but not driven low");
  a_ack_one_pulse: assert property ($rose(wb_ack) |=> !wb_ack)
    else $error("bus ack longer than one cycle");
  a_thm_shutdown: assert property (overtemp_shutdown [*4] |-> ##[0:4]
    (fault_n_oe && !converter_enable && !data_switch_close && !rp_enable))
    else $error("overtemp did not shut the port down");
  a_inov_bc_reset: assert property (input_overvoltage [*4] |-> ##[0:4]
    (fault_n_oe && bc12_reset && !converter_enable && !rp_enable))
    else $error("input overvoltage did not reset charger detection");
  a_sense_ov_off: assert property (sense_overvoltage [*4] |-> ##[0:4]
    (fault_n_oe && !converter_enable && !data_switch_close && !rp_enable))
    else $error("sense overvoltage did not shut the port down");
  a_short_gnd_off: assert property ((bus_overcurrent && sense_below_short) [*4]
    |-> ##[0:4] (fault_n_oe && !converter_enable && !data_switch_close))
    else $error("short to ground did not shut the port down");
  a_cable_oc_off: assert property (cable_run_q == VCONN_CYC + 32'h3 |-> ##[0:2]
    (fault_n_oe && !vconn_enable))
    else $error("cable power overcurrent left the switch on");
  a_fault_persists: assert property (overtemp_shutdown [*4] |=> fault_n_oe)
    else $error("fault released while overtemp present");
  a_retry_wait: assert property ($fell(fault_n_oe) |-> quiet_q >= RETRY_CYC)
    else $error("fault released before recovery wait ran out");
endmodule

bind ufs_supervisor ufs_supervisor_asserts #(
  .OVERTEMP_WARNING_FLAG_CYC(OVERTEMP_WARNING_FLAG_CYC),
  .OC_CYC(OC_CYC),
  .VCONN_CYC(VCONN_CYC),
  .RETRY_CYC(RETRY_CYC)
) chk_u (.core_clk, .rst, .wb_ack, .overtemp_shutdown, .input_overvoltage,
  .bus_overcurrent, .sense_below_short, .sense_overvoltage, .cable_power_overcurrent,
  .fault_n_out, .fault_n_oe, .converter_enable, .data_switch_close, .rp_enable,
  .bc12_reset, .vconn_enable);

`default_nettype wire

// ### ufs_hub_model.sv
/*
  hub controller overcurrent input: pulled-up fault line, counts reports.
  assumes the supervisor sinks the line only while reporting.
*/
`timescale 1ns/100ps
`default_nettype none

module ufs_hub_model
(
  // clock and reset
  input  wire logic  core_clk,
  input  wire logic  rst,
  // open-drain fault line
  input  wire logic  fault_n_out,
  input  wire logic  fault_n_oe,
  output logic       fault_n_in,
  // reports seen
  output logic [7:0] reports
);
  logic seen_q;

  // pull-up wins whenever nobody sinks the line
  assign fault_n_in = fault_n_oe ? fault_n_out : 1'b1;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      seen_q  <= 1'b1;
      reports <= 8'h00;
    end
    else
    begin
      seen_q <= fault_n_in;
      if (seen_q && !fault_n_in)
        reports <= reports + 8'h01;
    end
  end
endmodule

`default_nettype wire

// ### tb_usb_port_fault_supervisor.sv
/*
  testbench of the port fault supervisor: bus tasks, event table runs.
  assumes the hub model on the fault line and small timing parameters.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_usb_port_fault_supervisor;
  logic core_clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, snc, unat, irq;
  logic fault_n_in, fault_n_out, fault_n_oe, converter_enable, data_switch_close;
  logic rp_enable, bc12_reset, vconn_enable;
  logic [1:0]  advertised_current;
  logic [3:0]  wb_sel;
  logic [7:0]  wb_adr, reports;
  logic [10:0] cnd;
  logic [31:0] wb_wdat, wb_rdat, rd;
  int          bad_count, n_compared;
  logic [10:0] tc [10] = '{11'h001, 11'h004, 11'h008, 11'h080, 11'h010,
                           11'h020, 11'h200, 11'h030, 11'h050, 11'h030};
  logic [10:0] tf [10] = '{11'h001, 11'h004, 11'h008, 11'h100, 11'h010,
                           11'h040, 11'h400, 11'h070, 11'h080, 11'h070};
  logic [3:0]  to [10] = '{4'h0, 4'h1, 4'h1, 4'h0, 4'he, 4'he, 4'he, 4'h4, 4'h0, 4'he};

  ufs_supervisor #(.OVERTEMP_WARNING_FLAG_CYC(20), .OC_CYC(16), .VCONN_CYC(5), .RETRY_CYC(10)) dut_u (
    .core_clk, .rst, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_wdat, .wb_rdat,
    .wb_ack, .overtemp_shutdown(cnd[0]), .overtemp_warning(cnd[1]),
    .input_overvoltage(cnd[2]), .dataline_overvoltage(cnd[3]), .bus_overcurrent(cnd[4]),
    .sense_below_uv(cnd[5]), .sense_below_short(cnd[6]), .sense_overvoltage(cnd[7]),
    .cable_power_overcurrent(cnd[8]), .preon_overvoltage(cnd[9]),
    .switch_node_overcurrent(cnd[10]), .switch_node_cycle(snc), .cable_unattached(unat),
    .fault_n_in, .fault_n_out, .fault_n_oe, .irq, .converter_enable, .data_switch_close,
    .rp_enable, .bc12_reset, .vconn_enable, .advertised_current);

  ufs_hub_model hub_u (.core_clk, .rst, .fault_n_out, .fault_n_oe, .fault_n_in, .reports);

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ****************
  // tasks
  // ****************
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // one classic cycle; ack and data are taken at the edge that shows ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= a;
    wb_wdat <= d;
    i = 0;
    do
    begin
      @(posedge core_clk);
      i++;
    end
    while (wb_ack !== 1'b1 && i < 20);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (wb_ack !== 1'b1)
    begin
      bad_count++;
      $display("[ERR] %0t ns: bus answer missing", $time);
      conclude();
    end
  endtask

  // bounded wait on pin (0), current step (1) or cable power switch (2)
  task automatic wt(input int s, input logic [1:0] v);
    int i;
    logic [1:0] o;
    for (i = 0; i < 90; i++)
    begin
      o = s == 0 ? {1'b0, fault_n_in} : s == 1 ? advertised_current : {1'b0, vconn_enable};
      if (o === v)
        break;
      @(posedge core_clk);
    end
    if (i == 90)
    begin
      bad_count++;
      $display("[ERR] %0t ns: wait ran out", $time);
      conclude();
    end
  endtask

  task automatic run_ev(input logic [10:0] c, f, input logic [3:0] o, input bit deb);
    wb(1'b1, 8'h04, {21'h0, f});
    if (deb)
    begin
      repeat (2)
      begin
        cnd <= c;
        tick(12);
        cnd <= 11'h000;
        tick(1);
      end
      tick(8);
      chk(fault_n_in, 1'b1);
    end
    cnd <= c;
    wt(0, 2'h0);
    tick(1);
    chk(irq, 1'b1);
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, {21'h0, f});
    chk(irq, 1'b0);
    tick(2);
    chk(irq, 1'b1);
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, {21'h0, f});
    chk({converter_enable, data_switch_close, rp_enable, bc12_reset}, o);
    cnd <= 11'h000;
    tick(3);
    chk(fault_n_in, 1'b0);
    wt(0, 2'h1);
    chk({converter_enable, data_switch_close, rp_enable, bc12_reset}, 4'he);
    wb(1'b1, 8'h00, {21'h0, f});
    tick(1);
    chk(irq, 1'b0);
  endtask

  // ****************
  // sequence
  // ****************
  initial
  begin
    rst = 1'b1;
    {wb_cyc, wb_stb, wb_we, snc, unat} = 5'h00;
    {wb_adr, wb_wdat, cnd} = '0;
    wb_sel = 4'hf;
    bad_count = 0;
    n_compared = 0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    wb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h1e);
    wb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h013f_0000);
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    for (int k = 0; k < 10; k++)
    begin
      if (k == 9)
        wb(1'b1, 8'h08, 32'h1f);
      run_ev(tc[k], tf[k], to[k], k >= 4 && k != 8);
    end
    cnd <= 11'h002;
    wt(1, 2'h2);
    chk(fault_n_in, 1'b1);
    chk(irq, 1'b0);
    cnd <= 11'h000;
    tick(3);
    chk(advertised_current, 2'h2);
    wt(1, 2'h3);
    wb(1'b1, 8'h04, 32'h0);
    cnd <= 11'h100;
    wt(0, 2'h0);
    chk(vconn_enable, 1'b0);
    cnd <= 11'h000;
    wt(0, 2'h1);
    chk(vconn_enable, 1'b0);
    unat <= 1'b1;
    tick(3);
    unat <= 1'b0;
    wt(2, 2'h1);
    cnd <= 11'h440;
    repeat (3)
    begin
      tick(3);
      snc <= 1'b1;
      tick(3);
      snc <= 1'b0;
    end
    tick(4);
    chk(fault_n_in, 1'b1);
    snc <= 1'b1;
    wt(0, 2'h0);
    wb(1'b0, 8'h00, 32'h0);
    chk(rd[7], 1'b1);
    {cnd, snc} <= 12'h000;
    wt(0, 2'h1);
    chk(reports, 8'd12);
    conclude();
  end
endmodule

`default_nettype wire
